// ===== logic/jam_consts.svh
// Overview of operation
// - Condition code reads Normal 0, Start 1, Trip 2, Blocked 3.
// - Expected operating time in 5 ms steps, follows highest current in inverse mode.
// - Signed time remaining to trip counts down during a timed fault, 5 ms steps.
// - Ratio of highest phase current to pick-up setting reported continuously, 0.01 steps.
// - Blocking input sampled once at the start of each processing cycle.
// - Pick-up without blocking asserts START and starts operate timing.
// - Pick-up while blocked asserts BLOCKED and nothing further happens.
// - START on during operate timing clears when blocking arrives; once tripped, blocking is ignored.
// - Blocking raises a display event and a stamped event with currents and fault type.
// - ON and OFF events for START, TRIP, BLOCKED, each filtered by selection.
// - Every event carries a time stamp and process data.
// - Latest twelve stamped records of START, TRIP or BLOCKED ON data kept.
// - Record holds time, event, fault type, three currents, remaining time, group.
`ifndef JAM_CONSTS_SVH
`define JAM_CONSTS_SVH
`define COND_NORMAL   2'h0
`define COND_START    2'h1
`define COND_TRIP     2'h2
`define COND_BLOCKED  2'h3
`define EV_START_ON   3'h0
`define EV_START_OFF  3'h1
`define EV_TRIP_ON    3'h2
`define EV_TRIP_OFF   3'h3
`define EV_BLOCK_ON   3'h4
`define EV_BLOCK_OFF  3'h5
`define SEL_ON_BIT    0
`define SEL_OFF_BIT   1
`define REC_DEPTH     12
`define TIME_STEP_MS  5
`define TIME_MAX_TICK 24'h057e40
`define RATIO_SCALE   100
`endif

// ===== logic/jam_pkg.sv
package jam_pkg;
  typedef logic [63:0] stamp_t;
  typedef struct packed {
    logic [15:0] i_pre20;
    logic [15:0] i_now;
    logic [15:0] i_pre200;
    logic [2:0]  fault_type;
    logic [2:0]  group;
  } pdata_t;
  typedef struct packed {
    stamp_t      stamp;
    logic [2:0]  code;
    pdata_t      pdata;
    logic [23:0] remain;
  } event_t;
endpackage

// ===== logic/jam_record_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "jam_consts.svh"
module jam_record_store #(
  parameter int DEPTH = `REC_DEPTH
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Write side
  input  wire logic             i_wr,
  input  var  jam_pkg::event_t  i_rec,
  // Read side, index 0 is newest
  input  wire logic [3:0]       i_rd_idx,
  output var  jam_pkg::event_t  o_rd_rec,
  output logic [3:0]            o_count
);
  jam_pkg::event_t  mem [DEPTH];
  logic [3:0]       wp_r;
  logic [3:0]       cnt_r;
  logic [3:0]       rd_slot;

  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[wp_r] <= i_rec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wp_r  <= 4'h0;
      cnt_r <= 4'h0;
    end else if (i_wr) begin
      wp_r <= (wp_r == 4'(DEPTH - 1)) ? 4'h0 : wp_r + 4'h1;
      if (cnt_r != 4'(DEPTH)) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  always_comb begin
    rd_slot = (wp_r > i_rd_idx) ? wp_r - i_rd_idx - 4'h1 : 4'(DEPTH) + wp_r - i_rd_idx - 4'h1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rd_rec <= '0;
    end else if (i_rd_idx < cnt_r) begin
      o_rd_rec <= mem[rd_slot];
    end else begin
      o_rd_rec <= '0;
    end
  end

  assign o_count = cnt_r;
endmodule
`default_nettype wire

// ===== logic/jam_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "jam_consts.svh"
module jam_status #(
  parameter int DEPTH = `REC_DEPTH
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Program cycle and measurement
  input  wire logic              i_cycle_start,
  input  wire logic              i_pickup,
  input  wire logic              i_block,
  input  wire logic              i_idmt_mode,
  input  wire logic [23:0]       i_op_time,
  input  wire logic [23:0]       i_idmt_time,
  input  wire logic [15:0]       i_i_max,
  input  wire logic [15:0]       i_i_set,
  input  var  jam_pkg::pdata_t   i_pdata,
  input  var  jam_pkg::stamp_t   i_stamp,
  // Event selection, two bits per event: ON, OFF
  input  wire logic [11:0]       i_ev_sel,
  // Record readback
  input  wire logic [3:0]        i_rd_idx,
  output var  jam_pkg::event_t   o_rd_rec,
  output logic [3:0]             o_rec_count,
  // Status outputs
  output logic                   o_start,
  output logic                   o_trip,
  output logic                   o_blocked,
  output logic [1:0]             o_jam_condition_code,
  output logic [23:0]            o_expected_time,
  output logic signed [24:0]     o_remaining,
  output logic [15:0]            o_ratio,
  // Event outputs
  output logic                   o_disp_event,
  output logic                   o_ev_valid,
  output var  jam_pkg::event_t   o_event
);
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_TIMING  = 4'b0010,
    ST_TRIPPED = 4'b0100,
    ST_BLOCKED = 4'b1000
  } st_t;

  st_t          st_r, st_nxt;
  logic         blk_r;
  logic         blk_cur;
  logic         prev_start_r, prev_trip_r, prev_blk_r;
  logic [23:0]  exp_nxt;
  logic signed [24:0] rem_r;
  logic [5:0]   ev_pend;
  logic [5:0]   ev_fire;
  logic [5:0]   ev_all;
  logic [5:0]   ev_pick;
  logic [5:0]   ev_left_r;
  logic [31:0]  ratio_full;
  logic [2:0]   ev_code;
  logic         rec_wr;
  jam_pkg::event_t ev_nxt;

  function automatic logic is_on_event(input logic [2:0] c);
    return (c == `EV_START_ON) || (c == `EV_TRIP_ON) || (c == `EV_BLOCK_ON);
  endfunction

  // Block latched only at cycle start so a mid-cycle edge cannot split a decision
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      blk_r <= 1'b0;
    end else if (i_cycle_start) begin
      blk_r <= i_block;
    end
  end

  // The block seen at this cycle start decides this cycle, not the one before
  assign blk_cur = i_cycle_start ? i_block : blk_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (i_pickup && blk_cur) begin
          st_nxt = ST_BLOCKED;
        end else if (i_pickup) begin
          st_nxt = ST_TIMING;
        end
      end
      ST_TIMING: begin
        if (blk_cur) begin
          st_nxt = ST_BLOCKED;
        end else if (!i_pickup) begin
          st_nxt = ST_IDLE;
        end else if (rem_r <= 25'sd0) begin
          st_nxt = ST_TRIPPED;
        end
      end
      ST_TRIPPED: begin
        if (!i_pickup) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_BLOCKED: begin
        if (!blk_cur) begin
          st_nxt = i_pickup ? ST_TIMING : ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= ST_IDLE;
    end else if (i_cycle_start) begin
      st_r <= st_nxt;
    end
  end

  assign o_start   = (st_r == ST_TIMING) || (st_r == ST_TRIPPED);
  assign o_trip    = (st_r == ST_TRIPPED);
  assign o_blocked = (st_r == ST_BLOCKED);

  always_comb begin
    unique case (st_r)
      ST_TIMING:  o_jam_condition_code = `COND_START;
      ST_TRIPPED: o_jam_condition_code = `COND_TRIP;
      ST_BLOCKED: o_jam_condition_code = `COND_BLOCKED;
      default:    o_jam_condition_code = `COND_NORMAL;
    endcase
  end

  // Times are counted in 5 ms ticks, one tick per program cycle
  always_comb begin
    exp_nxt = i_idmt_mode ? i_idmt_time : i_op_time;
    if (exp_nxt > `TIME_MAX_TICK) begin
      exp_nxt = `TIME_MAX_TICK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_expected_time <= 24'h0;
    end else if (i_cycle_start) begin
      // Held between cycle starts so the inverse-mode re-base sees the whole step
      o_expected_time <= exp_nxt;
    end
  end

  // In inverse mode the remainder is re-based when the expected time moves
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rem_r <= 25'sd0;
    end else if (i_cycle_start) begin
      if (st_r == ST_TIMING && st_nxt == ST_TIMING) begin
        rem_r <= rem_r - 25'sd1 + (i_idmt_mode ? $signed({1'b0, exp_nxt}) - $signed({1'b0, o_expected_time})
                                               : 25'sd0);
      end else if (st_nxt == ST_TIMING) begin
        rem_r <= $signed({1'b0, exp_nxt});
      end else if (st_nxt != ST_TRIPPED) begin
        rem_r <= 25'sd0;
      end
    end
  end
  assign o_remaining = rem_r;

  // Combinational divide for the ratio: only a reporting value, so a slow iterative divide is not worth it
  assign ratio_full = (32'(i_i_max) * `RATIO_SCALE) / 32'((i_i_set == 16'h0) ? 16'h1 : i_i_set);

  // Saturates instead of wrapping when the ratio outgrows the port
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_ratio <= 16'h0;
    end else if (i_i_set == 16'h0 || ratio_full > 32'h0000ffff) begin
      o_ratio <= 16'hffff;
    end else begin
      o_ratio <= ratio_full[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      prev_start_r <= 1'b0;
      prev_trip_r  <= 1'b0;
      prev_blk_r   <= 1'b0;
    end else begin
      prev_start_r <= o_start;
      prev_trip_r  <= o_trip;
      prev_blk_r   <= o_blocked;
    end
  end

  assign ev_pend = {prev_blk_r & ~o_blocked, ~prev_blk_r & o_blocked,
                    prev_trip_r & ~o_trip, ~prev_trip_r & o_trip,
                    prev_start_r & ~o_start, ~prev_start_r & o_start};

  // Selection filters only the event output; record store still gets all ON data
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      ev_fire[k] = ev_pick[k] & i_ev_sel[2*k + ((k % 2 == 0) ? `SEL_ON_BIT : `SEL_OFF_BIT)];
    end
  end

  // Coinciding edges are queued and sent one per clock, lowest code first
  assign ev_all = ev_left_r | ev_pend;

  always_comb begin
    ev_code = `EV_START_ON;
    for (int k = 5; k >= 0; k--) begin
      if (ev_all[k]) begin
        ev_code = 3'(k);
      end
    end
    ev_pick       = (|ev_all) ? (6'h01 << ev_code) : 6'h00;
    ev_nxt.stamp  = i_stamp;
    ev_nxt.code   = ev_code;
    ev_nxt.pdata  = i_pdata;
    ev_nxt.remain = rem_r[24] ? 24'h0 : rem_r[23:0];
    rec_wr        = (|ev_all) && is_on_event(ev_code);
  end

  // Limitation: an event raised again before it drains merges with the queued one
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ev_left_r <= 6'h00;
    end else begin
      ev_left_r <= ev_all & ~ev_pick;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_ev_valid   <= 1'b0;
      o_event      <= '0;
      o_disp_event <= 1'b0;
    end else begin
      o_ev_valid   <= |ev_fire;
      o_event      <= ev_nxt;
      o_disp_event <= ev_pend[`EV_BLOCK_ON];
    end
  end

  jam_record_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_wr     (rec_wr),
    .i_rec    (ev_nxt),
    .i_rd_idx (i_rd_idx),
    .o_rd_rec (o_rd_rec),
    .o_count  (o_rec_count)
  );
endmodule
`default_nettype wire

// ===== tb/jam_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module jam_status_monitor #(
  parameter int DEPTH = 12
) (
  // Block inputs
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic              i_cycle_start,
  input wire logic              i_pickup,
  input wire logic              i_block,
  input wire logic              i_idmt_mode,
  input wire logic [23:0]       i_op_time,
  input wire logic [11:0]       i_ev_sel,
  // Block outputs
  input wire logic              o_start,
  input wire logic              o_trip,
  input wire logic              o_blocked,
  input wire logic [1:0]        o_jam_condition_code,
  input wire logic signed [24:0] o_remaining,
  input wire logic [3:0]        o_rec_count,
  input wire logic              o_disp_event,
  input wire logic              o_ev_valid,
  input var jam_pkg::event_t    o_event
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_blk_req;
    i_cycle_start && i_pickup && i_block && !o_trip;
  endsequence
  sequence s_start_ev;
    o_ev_valid && o_event.code == 3'h0;
  endsequence
  sequence s_blk_ev;
    o_ev_valid && o_event.code == 3'h4;
  endsequence
  a_code_map: assert property (
    o_jam_condition_code == (o_blocked ? 2'h3 : o_trip ? 2'h2 : o_start ? 2'h1 : 2'h0)
    && !(o_blocked && o_start) && !(o_trip && !o_start))
    else $error("code map");
  a_block_evt: assert property (
    $rose(o_blocked) && i_ev_sel[8] |-> ##[1:6] s_blk_ev) else $error("no block event");
  a_status_hold: assert property (
    !i_cycle_start |=> $stable({o_start, o_trip, o_blocked})) else $error("status moved");
  a_start_free: assert property (
    i_cycle_start && i_pickup && !i_block && !o_start && !o_trip |=> o_start) else $error("no start");
  a_block_pick: assert property (
    s_blk_req |=> o_blocked && !o_start) else $error("no block");
  a_disp_rise: assert property (
    $rose(o_blocked) |=> o_disp_event) else $error("no display event");
  a_start_evt: assert property (
    $rose(o_start) && i_ev_sel[0] |=> s_start_ev) else $error("no start event");
  a_remain_load: assert property (
    $rose(o_start) && !$past(i_idmt_mode) |-> o_remaining == 25'($past(i_op_time))) else $error("bad remaining");
  a_count_cap: assert property (
    o_rec_count <= DEPTH) else $error("store overfull");
endmodule
bind jam_status jam_status_monitor #(.DEPTH(DEPTH)) i_mon (.i_clk, .i_nrst, .i_cycle_start, .i_pickup,
  .i_block, .i_idmt_mode, .i_op_time, .i_ev_sel, .o_start, .o_trip, .o_blocked, .o_jam_condition_code,
  .o_remaining, .o_rec_count, .o_disp_event, .o_ev_valid, .o_event);
`default_nettype wire

// ===== tb/jam_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module jam_far_end (
  // Bench side
  input  wire logic i_clk,
  input  wire logic i_blk_req,
  // Block side
  input  wire logic i_ev_valid,
  output logic      o_block,
  output int        o_ev_cnt
);
  initial o_block = 1'b0;
  initial o_ev_cnt = 0;
  // Moves just after an edge, a whole cycle before the edge that samples it
  always @(posedge i_clk) o_block <= #1 i_blk_req;
  always @(posedge i_clk) if (i_ev_valid) o_ev_cnt <= o_ev_cnt + 1;
endmodule
`default_nettype wire

// ===== tb/jam_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jam_status_tb;
  localparam jam_pkg::pdata_t pd = {16'h0011, 16'h0022, 16'h0033, 3'h1, 3'h2};
  logic clk = 1'b0, nrst = 1'b0, cs = 1'b0, pick = 1'b0, req = 1'b0;
  logic blk, st, tr, bl, disp, evv;
  logic [11:0] sel = 12'hfff;
  logic [3:0] idx = 4'h0, n, cnt;
  logic [63:0] stamp = 64'h0;
  logic [63:0] ts;
  logic idmt = 1'b0;
  logic [23:0] idt = 24'h000004;
  logic [15:0] imax = 16'h00c8;
  logic [1:0] code;
  logic [23:0] expt;
  logic signed [24:0] rem;
  logic [15:0] ratio;
  jam_pkg::event_t ev, rd;
  int ev_cnt, k, err_total = 0, checked = 0, cyc = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    stamp <= #1 stamp + 64'h1;
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      end_sim();
    end
  end
  jam_far_end i_far (.i_clk(clk), .i_blk_req(req), .i_ev_valid(evv), .o_block(blk), .o_ev_cnt(ev_cnt));
  jam_status i_dut (.i_clk(clk), .i_nrst(nrst), .i_cycle_start(cs), .i_pickup(pick), .i_block(blk),
    .i_idmt_mode(idmt), .i_op_time(24'h000003), .i_idmt_time(idt), .i_i_max(imax),
    .i_i_set(16'h0064), .i_pdata(pd), .i_stamp(stamp), .i_ev_sel(sel), .i_rd_idx(idx), .o_rd_rec(rd),
    .o_rec_count(cnt), .o_start(st), .o_trip(tr), .o_blocked(bl), .o_jam_condition_code(code),
    .o_expected_time(expt), .o_remaining(rem), .o_ratio(ratio), .o_disp_event(disp), .o_ev_valid(evv),
    .o_event(ev));
  task automatic chk(input string nm, input logic [63:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Returns just after the edge where events of the taken cycle show
  task automatic go(input logic p, b);
    pick = p;
    req = b;
    n = cnt;
    @(posedge clk);
    #1 cs = 1'b1;
    @(posedge clk);
    #1 cs = 1'b0;
    @(posedge clk);
    ts = stamp;
    #1;
  endtask
  task automatic t_start();
    go(1'b1, 1'b0);
    chk("code", 2'h1, code);
    chk("rem", 64'h3, rem);
    chk("expt", 24'h3, expt);
    chk("ratio", 16'h00c8, ratio);
    chk("evcode", 3'h0, ev.code);
    chk("pdata", pd, ev.pdata);
    chk("stamp", ts, ev.stamp);
    chk("cnt", n + 4'h1, cnt);
  endtask
  task automatic t_trip();
    go(1'b1, 1'b0);
    chk("rem", 64'h2, rem);
    k = 0;
    while (tr !== 1'b1 && k < 6) begin
      go(1'b1, 1'b0);
      k++;
    end
    chk("code", 2'h2, code);
    go(1'b0, 1'b0);
    chk("code", 2'h0, code);
  endtask
  task automatic t_blk_pick();
    go(1'b1, 1'b1);
    chk("code", 2'h3, code);
    chk("disp", 1'b1, disp);
    chk("evcode", 3'h4, ev.code);
    chk("cnt", n + 4'h1, cnt);
    go(1'b0, 1'b0);
  endtask
  task automatic t_block();
    go(1'b1, 1'b0);
    go(1'b1, 1'b1);
    chk("code", 2'h3, code);
    chk("disp", 1'b1, disp);
    chk("evcode", 3'h1, ev.code);
    @(posedge clk);
    #1;
    chk("evcode", 3'h4, ev.code);
    chk("cnt", n + 4'h1, cnt);
  endtask
  task automatic t_refuse();
    sel = 12'h000;
    repeat (2) @(posedge clk);
    #1;
    k = ev_cnt;
    go(1'b1, 1'b0);
    chk("code", 2'h1, code);
    chk("evv", 1'b0, evv);
    chk("cnt", n + 4'h1, cnt);
    @(posedge clk);
    #1;
    chk("evcnt", k, ev_cnt);
    sel = 12'hfff;
  endtask
  task automatic t_idmt();
    idmt = 1'b1;
    go(1'b0, 1'b0);
    go(1'b1, 1'b0);
    chk("expt", 24'h4, expt);
    chk("rem", 64'h4, rem);
    idt = 24'h000008;
    imax = 16'h0096;
    go(1'b1, 1'b0);
    chk("expt", 24'h8, expt);
    chk("rem", 64'h7, rem);
    chk("ratio", 16'h0096, ratio);
    idt = 24'h000004;
    imax = 16'h00c8;
    idmt = 1'b0;
  endtask
  task automatic t_wrap();
    repeat (10) begin
      go(1'b0, 1'b0);
      go(1'b1, 1'b0);
    end
    chk("cnt", 4'hc, cnt);
    @(posedge clk);
    #1;
    chk("rdcode", 3'h0, rd.code);
    chk("rdpdata", pd, rd.pdata);
    idx = 4'hc;
    @(posedge clk);
    #1;
    chk("rdnone", 64'h0, {63'h0, |rd});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    chk("code", 2'h0, code);
    chk("cnt", 4'h0, cnt);
    t_start();
    t_trip();
    t_blk_pick();
    t_block();
    t_refuse();
    t_idmt();
    t_wrap();
    end_sim();
  end
endmodule
`default_nettype wire
